// >>> bench/isprl_host.sv
/* Host model: reset sources, straps and receive pin; idle pins high. */
`timescale 1ns/1ps
module isprl_host
    import isprl_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Toward the block
    output logic por_o,
    output logic pad_o,
    output isprl_pins_t pins_o
);
    initial begin
        por_o = 1'b0;
        pad_o = 1'b0;
        pins_o = 4'hF;
    end
    // Straps {a,b,c} held through reset, rx pulsed low rx times
    task automatic hw_reset(input logic pad, input logic [2:0] st,
                            input int rx);
        @(negedge mclk_i);
        por_o = !pad;
        pad_o = pad;
        pins_o[3:1] = st;
        for (int i = 0; i < 6; i++) begin
            @(negedge mclk_i);
            pins_o[0] = !(i % 2 == 0 && i / 2 < rx);
        end
        por_o = 1'b0;
        pad_o = 1'b0;
        @(negedge mclk_i);
        pins_o = 4'hF;
    endtask : hw_reset
endmodule : isprl_host

// >>> bench/isprl_top_asserts.sv
/* Port checker for isprl_top; bound to every instance of it. */
`timescale 1ns/1ps
module isprl_top_asserts
    import isprl_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Inputs
    input wire logic por_active_i,
    input wire logic pad_reset_i,
    input wire logic [4:0] lock_count_i,
    input wire logic protect_i,
    input wire isprl_flash_req_t flash_req_i,
    // Outputs
    input wire logic [13:0] region_start_o,
    input wire logic region_valid_o,
    input wire logic [13:0] boot_pc_o,
    input wire logic boot_valid_o,
    input wire logic isp_mode_o,
    input wire logic read_allow_o,
    input wire logic write_allow_o,
    input wire logic chip_erase_o,
    input wire logic [13:0] erase_keep_from_o
);
    logic [13:0] top;
    logic wr;
    logic inr;
    logic src;
    assign top = 14'(15'h4000 - {2'b00, lock_count_i, 8'h00});
    assign wr = flash_req_i.valid && !flash_req_i.erase_chip;
    assign inr = lock_count_i != 5'h00 && flash_req_i.addr >= top;
    assign src = por_active_i || pad_reset_i;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    AST_REGION: assert property (
        1'b1 |=> region_start_o == $past(top)
        && region_valid_o == ($past(lock_count_i) != 5'h00))
        else $error("region start or valid wrong");
    AST_READ: assert property (
        1'b1 |=> read_allow_o == !$past(protect_i))
        else $error("read allow wrong");
    AST_WR_IN: assert property (wr && inr |=> !write_allow_o)
        else $error("write inside region allowed");
    AST_WR_OUT: assert property (wr && !inr |=> write_allow_o)
        else $error("write outside region refused");
    AST_KEEP: assert property (
        flash_req_i.valid && flash_req_i.erase_chip
        |=> chip_erase_o && erase_keep_from_o ==
        ($past(lock_count_i) != 5'h00 ? $past(top) : ISPRL_FLASH_LAST))
        else $error("chip erase keep address wrong");
    AST_PULSE: assert property (boot_valid_o |=> !boot_valid_o)
        else $error("boot valid longer than one cycle");
    AST_BOOT_TIME: assert property (
        $fell(src) |-> ##2 boot_valid_o)
        else $error("boot not two cycles after reset");
    AST_BOOT_PC: assert property (
        boot_valid_o |-> boot_pc_o ==
        (isp_mode_o ? region_start_o : ISPRL_RESET_VECTOR))
        else $error("boot address wrong");
    cover property (boot_valid_o && isp_mode_o);
    cover property ($rose(isp_mode_o) && !boot_valid_o);
    cover property (chip_erase_o && region_valid_o);
endmodule : isprl_top_asserts

bind isprl_top isprl_top_asserts i_asserts (.mclk_i, .reset_n_i,
    .por_active_i, .pad_reset_i, .lock_count_i, .protect_i, .flash_req_i,
    .region_start_o, .region_valid_o, .boot_pc_o, .boot_valid_o,
    .isp_mode_o, .read_allow_o, .write_allow_o, .chip_erase_o,
    .erase_keep_from_o);

// >>> bench/test_isp_region_lock_and_entry.sv
/* Self-checking bench for isprl_top, driven with the host model. */
`timescale 1ns/1ps
module test_isp_region_lock_and_entry;
    import isprl_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n = 1'b0;
    logic por, pad, rv, bv, isp, rd, wr, ce;
    isprl_pins_t pins;
    logic [4:0] lock = 5'h10;
    logic [7:0] sel = 8'h00;
    logic prot = 1'b0;
    isprl_pmode_t pm = ISPRL_PM_ACTIVE;
    logic [7:0] b0 = 8'h00;
    logic jmp = 1'b0;
    logic [13:0] ja = 14'h0000;
    isprl_flash_req_t req = '0;
    logic [13:0] start, pc, keep;
    logic [3:0] flags;
    int num_errors = 0;
    int samples_checked = 0;
    initial forever #12.5 mclk_i = ~mclk_i;
    isprl_host i_host (.mclk_i, .por_o(por), .pad_o(pad), .pins_o(pins));
    isprl_top i_dut (.mclk_i, .reset_n_i(rst_n), .por_active_i(por),
        .pad_reset_i(pad), .lock_count_i(lock), .entry_sel_i(sel),
        .protect_i(prot), .pmode_i(pm), .pins_i(pins),
        .flash_byte0_i(b0), .jump_i(jmp), .jump_addr_i(ja),
        .read_addr_i(ja), .flash_req_i(req), .region_start_o(start),
        .region_valid_o(rv), .boot_pc_o(pc), .boot_valid_o(bv),
        .isp_mode_o(isp), .entry_path_flag_o(flags), .read_allow_o(rd),
        .write_allow_o(wr), .chip_erase_o(ce), .erase_keep_from_o(keep));
    function automatic logic [13:0] top(input logic [4:0] n);
        return 14'(15'h4000 - {2'b00, n, 8'h00});
    endfunction : top
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_boot();
        for (int i = 0; i < 20 && bv !== 1'b1; i++) @(posedge mclk_i) #1;
        check(14'(bv), 14'h1);
    endtask : wait_boot
    task automatic t_region();
        for (int n = 0; n <= 16; n++) begin
            @(negedge mclk_i);
            lock = 5'(n);
            prot = 1'(n);
            @(negedge mclk_i);
            req = '{1'b1, 1'b0, 1'b0, top(lock) - 14'h1};
            check(start, top(lock));
            check(14'(rv), 14'(n != 0));
            check(14'(rd), 14'(n % 2 == 0));
            @(negedge mclk_i);
            req = '{1'b1, 1'b0, 1'b1, top(lock)};
            check(14'(wr), 14'h1);
            @(negedge mclk_i);
            req = '{1'b1, 1'b1, 1'b0, 14'h0000};
            check(14'(wr), 14'(n == 0));
            @(negedge mclk_i);
            req = '0;
            check(14'(ce), 14'h1);
            check(keep, n == 0 ? 14'h3FFF : top(lock));
        end
    endtask : t_region
    task automatic t_entry();
        int m;
        int t;
        for (int k = 0; k < 16; k++) begin
            m = k % 8;
            t = m / 2;
            @(negedge mclk_i);
            sel = 8'h01 << (k < 8 ? m : m ^ 1);
            lock = 5'(m + 9);
            b0 = t == 0 ? 8'hFF : 8'h00;
            i_host.hw_reset(1'(m), t == 1 ? 3'b001 : t == 2 ? 3'b110
                : 3'b111, t == 3 ? 2 : 0);
            wait_boot();
            check(14'(isp), 14'(k < 8));
            check(pc, k < 8 ? top(lock) : ISPRL_RESET_VECTOR);
            check(14'(flags), k < 8 ? 14'h1 << t : 14'h0);
        end
    endtask : t_entry
    task automatic t_refuse();
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk_i);
            sel = 8'hFF;
            b0 = 8'hFF;
            lock = i == 0 ? 5'h00 : 5'h10;
            pm = i == 1 ? ISPRL_PM_DOWN : i == 2 ? ISPRL_PM_IDLE
                : ISPRL_PM_ACTIVE;
            i_host.hw_reset(1'b0, 3'b111, 0);
            wait_boot();
            check(14'(isp), 14'(i == 2));
        end
    endtask : t_refuse
    task automatic t_jump();
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk_i);
            pm = i == 3 ? ISPRL_PM_DOWN : ISPRL_PM_ACTIVE;
            ja = i % 2 == 1 ? top(lock) : ISPRL_RESET_VECTOR;
            jmp = 1'b1;
            @(negedge mclk_i);
            jmp = 1'b0;
            @(negedge mclk_i);
            check(14'(isp), 14'(i == 1));
        end
    endtask : t_jump
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(negedge mclk_i);
        rst_n = 1'b1;
        t_region();
        t_entry();
        t_refuse();
        t_jump();
        summarize();
    end
    initial begin
        repeat (3000) @(posedge mclk_i);
        num_errors++;
        summarize();
    end
endmodule : test_isp_region_lock_and_entry

// >>> rtl/isprl_pkg.sv
/*
 * Constants and carrier types for the service-region lock and entry block.
 * Assumes a 16K-byte program flash with 14-bit byte addresses.
 */
package isprl_pkg;

    localparam int ISPRL_AW = 14;
    localparam logic [14:0] ISPRL_FLASH_TOP = 15'h4000;
    localparam logic [4:0] ISPRL_LOCK_MAX = 5'h10;
    localparam int ISPRL_BLOCK_SHIFT = 8;
    localparam logic [7:0] ISPRL_BLANK_BYTE = 8'hFF;
    localparam logic [13:0] ISPRL_RESET_VECTOR = 14'h0000;
    localparam logic [13:0] ISPRL_FLASH_LAST = 14'h3FFF;
    localparam logic ISPRL_RX_IDLE = 1'b1;
    localparam logic [1:0] ISPRL_RX_CLOCKS = 2'h2;
    localparam logic [7:0] ISPRL_ENTRY_SEL_RST = 8'h00;
    localparam logic [3:0] ISPRL_FLAGS_RST = 4'h0;

    // Entry trigger bit positions in the flag vector
    localparam int ISPRL_TRIG_BLANK = 0;
    localparam int ISPRL_TRIG_STRAP2 = 1;
    localparam int ISPRL_TRIG_STRAP4 = 2;
    localparam int ISPRL_TRIG_RXCLK = 3;

    typedef enum logic [2:0] {
        ISPRL_PM_ACTIVE = 3'b001,
        ISPRL_PM_IDLE = 3'b010,
        ISPRL_PM_DOWN = 3'b100
    } isprl_pmode_t;

    typedef enum logic [2:0] {
        ISPRL_ST_RESET = 3'b001,
        ISPRL_ST_WATCH = 3'b010,
        ISPRL_ST_RUN = 3'b100
    } isprl_state_t;

    // Flash write/erase request from the flash controller
    typedef struct packed {
        logic valid;
        logic erase_chip;
        logic erase_page;
        logic [13:0] addr;
    } isprl_flash_req_t;

    // Straps and receive pin as sampled during reset
    typedef struct packed {
        logic strap_pin_a;
        logic strap_pin_b;
        logic strap_pin_c;
        logic serial_rx_entry_pin;
    } isprl_pins_t;

endpackage : isprl_pkg

// >>> rtl/isprl_top.sv
/*
 * Service-region lock and boot-entry logic of the program flash.
 * Assumes synchronous pins, reset sources given as levels on mclk_i and
 * the lock count and entry selects held stable by the option store.
 */
// Function
// RL1: Region size is lock count times 256 bytes, count 0 to 16, top 4K.
// RL2: Lock count zero means no region; all flash is program memory.
// RL3: Region grows down from top address, start is a 256-byte multiple.
// RL4: Start equals 0x4000 minus count times 256; empty when count zero.
// RL5: Chip erase spares every byte inside the locked region.
// RL6: Region readable unless protected; protection blocks all flash reads.
// RL7: Programmed region locks itself; only an external writer alters it.
// RL8: Service program may start in active or idle, never power-down.
// RL9: Reset with blank byte zero loads the region start into the PC.
// RL10: Firmware may enter by a jump to the region start.
// RL11: Enter when both port-2 straps or the port-4 strap are low at reset.
// RL12: Enter when two clocks appear on the receive pin around reset.
// RL13: Eight entry choices: four triggers times power-on or pad reset.
// RL14: Straps and receive pin sampled in reset; any enabled match enters.
// RL15: Return to firmware by reset, watchdog reset or jump to zero.
// RL16: System holds straps inactive in reset unless entry is wanted.
// RL17: Program or page erase aimed inside the region has no effect.
// RL18: Four read-only entry-path flags report the path, cleared by reset.
`timescale 1ns/1ps
module isprl_top
    import isprl_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Reset sources, high while held
    input wire logic por_active_i,
    input wire logic pad_reset_i,
    // Option settings
    input wire logic [4:0] lock_count_i,
    input wire logic [7:0] entry_sel_i,
    input wire logic protect_i,
    input wire isprl_pmode_t pmode_i,
    // Pins
    input wire isprl_pins_t pins_i,
    // Flash byte zero and core fetch
    input wire logic [7:0] flash_byte0_i,
    input wire logic jump_i,
    input wire logic [13:0] jump_addr_i,
    input wire logic [13:0] read_addr_i,
    // Flash write and erase requests
    input wire isprl_flash_req_t flash_req_i,
    // Outputs
    output logic [13:0] region_start_o,
    output logic region_valid_o,
    output logic [13:0] boot_pc_o,
    output logic boot_valid_o,
    output logic isp_mode_o,
    output logic [3:0] entry_path_flag_o,
    output logic read_allow_o,
    output logic write_allow_o,
    output logic chip_erase_o,
    output logic [13:0] erase_keep_from_o
);

    isprl_state_t state;
    isprl_state_t next_state;
    logic [4:0] lock_count;
    logic [14:0] next_start;
    logic region_on;
    logic in_reset;
    logic pad_seen;
    logic rx_prev;
    logic [1:0] rx_clocks;
    logic [2:0] trig;
    logic rx_done;
    logic [3:0] hits;
    logic [3:0] enabled;
    logic active_ok;
    logic in_region_w;
    logic in_region_r;
    logic entry;

    // Counts above 16 are clamped to the 4K window
    always_comb begin
        lock_count = (lock_count_i > ISPRL_LOCK_MAX) ? ISPRL_LOCK_MAX
                     : lock_count_i; // see RL1
    end

    // Region grows down from the top; a zero count leaves it empty
    always_comb begin
        next_start = ISPRL_FLASH_TOP
                     - {2'h0, lock_count, 8'h00}; // see RL4
        region_on = (lock_count != 5'h00); // see RL2
    end

    // Start of the region as seen by the core, refreshed every cycle
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            region_start_o <= ISPRL_RESET_VECTOR;
        end else begin
            region_start_o <= next_start[13:0]; // see RL3
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            region_valid_o <= 1'b0;
        end else begin
            region_valid_o <= region_on; // see RL2
        end
    end

    // Either source opens a hardware reset period
    assign in_reset = por_active_i | pad_reset_i;

    always_comb begin
        next_state = state;
        case (state)
            ISPRL_ST_RESET: begin
                if (!in_reset) begin
                    next_state = ISPRL_ST_WATCH;
                end
            end
            ISPRL_ST_WATCH: begin
                next_state = ISPRL_ST_RUN;
            end
            ISPRL_ST_RUN: begin
                if (in_reset) begin
                    next_state = ISPRL_ST_RESET;
                end
            end
            default: begin
                next_state = ISPRL_ST_RESET;
            end
        endcase
    end

    // Reset period, one watch cycle for the decision, then run
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ISPRL_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Which reset source opened this period; pad wins if both seen
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_seen <= 1'b0;
        end else if (state == ISPRL_ST_RUN && in_reset) begin
            pad_seen <= pad_reset_i;
        end else if (state == ISPRL_ST_RESET && pad_reset_i) begin
            pad_seen <= 1'b1;
        end
    end

    // Pin idles high, so the edge detector resets high: no false edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_prev <= ISPRL_RX_IDLE;
        end else begin
            rx_prev <= pins_i.serial_rx_entry_pin;
        end
    end

    // Rising edges on the receive pin, counted in and just after reset
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_clocks <= 2'h0;
        end else if (state == ISPRL_ST_RUN) begin
            rx_clocks <= 2'h0;
        end else if (pins_i.serial_rx_entry_pin && !rx_prev
                     && rx_clocks != ISPRL_RX_CLOCKS) begin
            rx_clocks <= rx_clocks + 2'h1; // see RL12
        end
    end

    // Blank byte zero and strap levels sampled while reset is held
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trig <= 3'h0;
        end else if (state == ISPRL_ST_RESET) begin
            trig[ISPRL_TRIG_BLANK] <= (flash_byte0_i
                                       == ISPRL_BLANK_BYTE); // see RL9
            trig[ISPRL_TRIG_STRAP2] <= !pins_i.strap_pin_a
                                       && !pins_i.strap_pin_b; // see RL11
            trig[ISPRL_TRIG_STRAP4] <= !pins_i.strap_pin_c; // see RL11
        end
    end

    // Even select bits pair with power-on reset, odd with pad reset
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            enabled[i] = pad_seen ? entry_sel_i[2*i+1]
                         : entry_sel_i[2*i]; // see RL13
        end
    end

    // Service program never starts from power-down
    assign active_ok = (pmode_i != ISPRL_PM_DOWN); // see RL8

    // Triggers met whose entry choice matches the reset source seen
    always_comb begin
        rx_done = (rx_clocks == ISPRL_RX_CLOCKS); // see RL12
        hits = enabled & {rx_done, trig}; // see RL13
    end

    always_comb begin
        entry = 1'b0;
        if (state == ISPRL_ST_WATCH && region_on && active_ok) begin
            entry = |hits; // see RL14
        end
    end

    // Boot vector decided one cycle after reset release
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_valid_o <= 1'b0;
        end else begin
            boot_valid_o <= (state == ISPRL_ST_WATCH); // see RL14
        end
    end

    // Program counter the core starts from after each reset period
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_pc_o <= ISPRL_RESET_VECTOR;
        end else if (state == ISPRL_ST_WATCH) begin
            boot_pc_o <= entry ? next_start[13:0]
                         : ISPRL_RESET_VECTOR; // see RL9
        end
    end

    // Flags clear through the reset period, set at the decision
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            entry_path_flag_o <= ISPRL_FLAGS_RST;
        end else if (state == ISPRL_ST_RESET) begin
            entry_path_flag_o <= ISPRL_FLAGS_RST; // see RL18
        end else if (state == ISPRL_ST_WATCH && entry) begin
            entry_path_flag_o <= hits; // see RL18
        end
    end

    // Service mode by reset entry or by a jump; left by jump to zero
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            isp_mode_o <= 1'b0;
        end else if (state != ISPRL_ST_RUN) begin
            isp_mode_o <= entry; // see RL14
        end else if (jump_i && region_on && active_ok
                     && jump_addr_i == next_start[13:0]) begin
            isp_mode_o <= 1'b1; // see RL10
        // A jump to zero hands control back to the firmware
        end else if (jump_i && jump_addr_i == ISPRL_RESET_VECTOR) begin
            isp_mode_o <= 1'b0; // see RL15
        end
    end

    // Requests and reads that fall inside the locked region
    always_comb begin
        in_region_w = region_on
            && ({1'b0, flash_req_i.addr} >= next_start); // see RL17
        in_region_r = region_on && ({1'b0, read_addr_i} >= next_start);
    end

    // Protection blocks every read, the region's own included
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_allow_o <= 1'b0;
        end else begin
            read_allow_o <= !protect_i
                && (in_region_r || !in_region_r); // see RL6
        end
    end

    // Region is never writable in system; only an external writer can
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            write_allow_o <= 1'b0;
        end else begin
            write_allow_o <= flash_req_i.valid && !flash_req_i.erase_chip
                             && !in_region_w; // see RL7
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chip_erase_o <= 1'b0;
        end else begin
            chip_erase_o <= flash_req_i.valid
                            && flash_req_i.erase_chip; // see RL5
        end
    end

    // First address a chip erase must spare; top address when no region
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            erase_keep_from_o <= ISPRL_RESET_VECTOR;
        end else begin
            erase_keep_from_o <= region_on ? next_start[13:0]
                                 : ISPRL_FLASH_LAST; // see RL5
        end
    end

endmodule : isprl_top
